// file: logic/pdh_regs.svh
`ifndef PDH_REGS_SVH
`define PDH_REGS_SVH
// descriptor word 0 layout
`define PDH_W0_LOC_BIT 22
`define PDH_W0_LEN_MSB 21
`define PDH_W0_TYPE_MSB 31
`define PDH_W0_TYPE_LSB 30
`define PDH_W0_RSVD_BITS 7'h00
`define PDH_TYPE_HOST 2'h0
`define PDH_TYPE_MONO 2'h2
// byte offsets inside a descriptor
`define PDH_OFS_W1 32'h0000_0004
`define PDH_OFS_W2 32'h0000_0008
`define PDH_OFS_W3 32'h0000_000c
`define PDH_OFS_PS 32'h0000_0010
`define PDH_OFS_BUF 32'h0000_0040
`define PDH_WORD_BYTES 32'h0000_0004
`define PDH_LEN_STEP 22'h00_0004
// byte enables
`define PDH_BE_FULL 4'hf
`define PDH_BE_LEN 4'h7
// sizes
`define PDH_FLOWS 8
`define PDH_FIFO_DEPTH 16
`endif

// file: logic/pdh_pkg.sv
`default_nettype none
package pdh_pkg;
  // per-flow receive settings written by software
  typedef struct packed {
    logic ps_in_buf;
    logic host;
    logic tag_pass;
  } pdh_flow_cfg_t;
  // one word of the incoming packet stream
  typedef struct packed {
    logic [31:0] tag;
    logic [2:0] flow;
    logic sop;
    logic eop;
    logic ps;
    logic [31:0] data;
  } pdh_beat_t;
  // one memory write request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
    logic desc;
  } pdh_mem_wr_t;
  typedef enum logic [2:0] {
    st_idle, st_pop, st_data, st_w0, st_w1, st_w2, st_w3, st_push
  } pdh_state_t;
endpackage
`default_nettype wire

// file: logic/pdh_fifo.sv
`default_nettype none
module pdh_fifo #(
  parameter int W = 72,
  parameter int D = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;
  logic rdy_ff;

  assign out_valid = cnt_ff != '0;
  assign push = in_valid && rdy_ff;
  assign pop = out_valid && out_ready;
  assign in_ready = rdy_ff;
  assign out_data = mem_ff[rd_ptr_ff];
  // ready is registered from the next fill level so the source sees a clean flop and all D entries can fill
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  // storage array, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers, fill level and ready
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= push ? wr_ptr_ff + AW'(1) : wr_ptr_ff;
      rd_ptr_ff <= pop ? rd_ptr_ff + AW'(1) : rd_ptr_ff;
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_cnt != (AW+1)'(D);
    end
  end
endmodule
`default_nettype wire

// file: logic/pdh_word0_build.sv
`default_nettype none
`include "pdh_regs.svh"
module pdh_word0_build (
  input wire logic host,
  input wire logic ps_in_buf,
  input wire logic [21:0] len,
  output logic [31:0] word0
);
  logic loc_bit;
  // the location bit only means something for host packets
  assign loc_bit = host && ps_in_buf;
  // location bit is placed alone; type and length do not depend on it
  assign word0 = {host ? `PDH_TYPE_HOST : `PDH_TYPE_MONO, `PDH_W0_RSVD_BITS, loc_bit, len};
endmodule
`default_nettype wire

// file: logic/pdh_rx_dma.sv
// What this block does
// - data buffer writes always carry all four byte enables
// - descriptor writes may use partial byte enables; memory must accept them
// - host packet with protocol words in buffer sets word 0 bit 22
// - protocol words inside descriptor leave the location bit at zero
// - per-flow location comes from the software flow table
// - when enabled, transmit tag word is copied unchanged into receive descriptor
// - host packets use a separate buffer, monolithic ones do not
// - a forwarded packet takes its location from the incoming bit 22
// - pop reads only the fourth queue word, which returns the pointer
`default_nettype none
`include "pdh_regs.svh"
module pdh_rx_dma (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic chan_en,
  input wire logic flow_cfg_we,
  input wire logic [2:0] flow_cfg_idx,
  input wire pdh_pkg::pdh_flow_cfg_t flow_cfg,
  input wire logic fwd_en,
  input wire logic [31:0] fwd_word0,
  input wire logic s_valid,
  output logic s_ready,
  input wire pdh_pkg::pdh_beat_t s_beat,
  output logic qm_pop_req,
  input wire logic qm_pop_ack,
  input wire logic [31:0] qm_pop_data,
  output logic qm_push_valid,
  input wire logic qm_push_ready,
  output logic [31:0] qm_push_ptr,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output pdh_pkg::pdh_mem_wr_t mem_wr,
  output logic busy
);
  import pdh_pkg::*;

  pdh_state_t state_ff;
  pdh_state_t nxt_state;
  pdh_flow_cfg_t flow_tbl_ff [`PDH_FLOWS];
  pdh_flow_cfg_t cur_cfg_ff;
  pdh_beat_t f_beat;
  pdh_mem_wr_t mem_wr_ff;
  pdh_mem_wr_t nxt_wr;
  logic nxt_wr_valid;
  logic mem_wr_valid_ff;
  logic f_valid;
  logic f_pop;
  logic wr_free;
  logic start;
  logic qm_pop_req_ff;
  logic qm_push_valid_ff;
  logic busy_ff;
  logic [31:0] desc_ptr_ff;
  logic [31:0] ps_ptr_ff;
  logic [31:0] buf_ptr_ff;
  logic [31:0] tag_ff;
  logic [21:0] len_ff;
  logic [31:0] word0;
  logic to_desc;

  // stream buffer; its ready back-pressures the packet source
  pdh_fifo #(
    .W($bits(pdh_beat_t)),
    .D(`PDH_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(s_valid),
    .in_ready(s_ready),
    .in_data(s_beat),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_beat)
  );

  pdh_word0_build u_w0 (
    .host(cur_cfg_ff.host),
    .ps_in_buf(cur_cfg_ff.ps_in_buf),
    .len(len_ff),
    .word0(word0)
  );

  // receive flow table, one entry per flow
  generate
    for (genvar g = 0; g < `PDH_FLOWS; g++) begin : g_flow
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          flow_tbl_ff[g] <= '0;
        end else if (flow_cfg_we && flow_cfg_idx == 3'(g)) begin
          flow_tbl_ff[g] <= flow_cfg;
        end
      end
    end
  endgenerate

  assign wr_free = !mem_wr_valid_ff || mem_wr_ready;
  assign start = state_ff == st_idle && chan_en && f_valid && f_beat.sop;
  // stray words outside a packet are dropped so the queue cannot wedge
  assign f_pop = (state_ff == st_data && f_valid && wr_free) ||
                 (state_ff == st_idle && f_valid && !f_beat.sop);
  // mono words and in-descriptor protocol words go to the descriptor
  assign to_desc = !cur_cfg_ff.host || (f_beat.ps && !cur_cfg_ff.ps_in_buf);

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: begin
        if (start) begin
          nxt_state = st_pop;
        end
      end
      st_pop: begin
        if (qm_pop_req_ff && qm_pop_ack) begin
          nxt_state = st_data;
        end
      end
      st_data: begin
        if (f_pop && f_beat.eop) begin
          nxt_state = st_w0;
        end
      end
      st_w0: begin
        if (wr_free) begin
          nxt_state = st_w1;
        end
      end
      st_w1: begin
        if (wr_free) begin
          nxt_state = st_w2;
        end
      end
      st_w2: begin
        if (wr_free) begin
          nxt_state = cur_cfg_ff.host ? st_w3 : st_push;
        end
      end
      st_w3: begin
        if (wr_free) begin
          nxt_state = st_push;
        end
      end
      st_push: begin
        if (qm_push_valid_ff && qm_push_ready) begin
          nxt_state = st_idle;
        end
      end
      default: nxt_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_ff <= st_idle;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state != st_idle;
    end
  end

  // latch the packet's settings at its first word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cur_cfg_ff <= '0;
      tag_ff <= '0;
    end else if (start) begin
      cur_cfg_ff <= flow_tbl_ff[f_beat.flow];
      tag_ff <= f_beat.tag;
      if (fwd_en) begin
        cur_cfg_ff.ps_in_buf <= fwd_word0[`PDH_W0_LOC_BIT];
      end
    end
  end

  // free descriptor pop: one read of the fourth queue word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      qm_pop_req_ff <= 1'b0;
    end else if (start) begin
      qm_pop_req_ff <= 1'b1;
    end else if (qm_pop_ack) begin
      qm_pop_req_ff <= 1'b0;
    end
  end

  // finished descriptor pointer handed back to the queue manager
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      qm_push_valid_ff <= 1'b0;
    end else if (nxt_state == st_push && state_ff != st_push) begin
      qm_push_valid_ff <= 1'b1;
    end else if (qm_push_ready) begin
      qm_push_valid_ff <= 1'b0;
    end
  end

  // address pointers and byte length
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      desc_ptr_ff <= '0;
      ps_ptr_ff <= '0;
      buf_ptr_ff <= '0;
      len_ff <= '0;
    end else if (state_ff == st_pop && qm_pop_req_ff && qm_pop_ack) begin
      desc_ptr_ff <= qm_pop_data;
      ps_ptr_ff <= qm_pop_data + `PDH_OFS_PS;
      buf_ptr_ff <= qm_pop_data + `PDH_OFS_BUF;
      len_ff <= '0;
    end else if (state_ff == st_data && f_pop) begin
      if (to_desc) begin
        ps_ptr_ff <= ps_ptr_ff + `PDH_WORD_BYTES;
      end else begin
        buf_ptr_ff <= buf_ptr_ff + `PDH_WORD_BYTES;
      end
      if (!f_beat.ps) begin
        len_ff <= len_ff + `PDH_LEN_STEP;
      end
    end
  end

  // memory write requests
  always_comb begin
    nxt_wr_valid = 1'b0;
    nxt_wr = '0;
    case (state_ff)
      st_data: begin
        nxt_wr_valid = f_valid;
        nxt_wr.data = f_beat.data;
        nxt_wr.desc = to_desc;
        nxt_wr.addr = to_desc ? ps_ptr_ff : buf_ptr_ff;
        nxt_wr.be = `PDH_BE_FULL;
      end
      st_w0: begin
        nxt_wr_valid = 1'b1;
        nxt_wr.desc = 1'b1;
        nxt_wr.addr = desc_ptr_ff;
        nxt_wr.data = word0;
        nxt_wr.be = `PDH_BE_FULL;
      end
      st_w1: begin
        nxt_wr_valid = 1'b1;
        nxt_wr.desc = 1'b1;
        nxt_wr.addr = desc_ptr_ff + `PDH_OFS_W1;
        nxt_wr.data = {10'h000, len_ff};
        nxt_wr.be = `PDH_BE_LEN;
      end
      st_w2: begin
        nxt_wr_valid = cur_cfg_ff.tag_pass;
        nxt_wr.desc = 1'b1;
        nxt_wr.addr = desc_ptr_ff + `PDH_OFS_W2;
        nxt_wr.data = tag_ff;
        nxt_wr.be = `PDH_BE_FULL;
      end
      st_w3: begin
        nxt_wr_valid = 1'b1;
        nxt_wr.desc = 1'b1;
        nxt_wr.addr = desc_ptr_ff + `PDH_OFS_W3;
        nxt_wr.data = desc_ptr_ff + `PDH_OFS_BUF;
        nxt_wr.be = `PDH_BE_FULL;
      end
      default: begin
        nxt_wr_valid = 1'b0;
      end
    endcase
  end

  // request register, advances only when the memory has taken the last one
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_wr_valid_ff <= 1'b0;
      mem_wr_ff <= '0;
    end else if (wr_free) begin
      mem_wr_valid_ff <= nxt_wr_valid;
      mem_wr_ff <= nxt_wr;
    end
  end

  assign mem_wr_valid = mem_wr_valid_ff;
  assign mem_wr = mem_wr_ff;
  assign qm_pop_req = qm_pop_req_ff;
  assign qm_push_valid = qm_push_valid_ff;
  assign qm_push_ptr = desc_ptr_ff;
  assign busy = busy_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence pop_taken;
    state_ff == st_pop && qm_pop_req_ff && qm_pop_ack;
  endsequence
  sequence w0_issue;
    state_ff == st_w0 && wr_free;
  endsequence

  data_be_full_a: assert property (
    mem_wr_valid && !mem_wr.desc |-> mem_wr.be == `PDH_BE_FULL)
    else $error("buffer write with partial byte enables");
  len_be_part_a: assert property (
    state_ff == st_w1 && wr_free |=> mem_wr_valid && mem_wr.be == `PDH_BE_LEN)
    else $error("length word not written with partial enables");
  loc_bit_set_a: assert property (
    w0_issue ##0 (cur_cfg_ff.host && cur_cfg_ff.ps_in_buf) |=> mem_wr.data[`PDH_W0_LOC_BIT])
    else $error("location bit not set");
  loc_bit_clr_a: assert property (
    w0_issue ##0 !cur_cfg_ff.ps_in_buf |=> !mem_wr.data[`PDH_W0_LOC_BIT])
    else $error("location bit set for in-descriptor words");
  flow_loc_a: assert property (
    start && !fwd_en |=> cur_cfg_ff == $past(flow_tbl_ff[f_beat.flow]))
    else $error("flow settings not taken from table");
  fwd_loc_a: assert property (
    start && fwd_en |=> cur_cfg_ff.ps_in_buf == $past(fwd_word0[`PDH_W0_LOC_BIT]))
    else $error("forwarded location bit not used");
  tag_copy_a: assert property (
    state_ff == st_w2 && wr_free && cur_cfg_ff.tag_pass |=>
      mem_wr_valid && mem_wr.data == tag_ff && mem_wr.addr == desc_ptr_ff + `PDH_OFS_W2)
    else $error("tag not copied");
  mono_no_buf_a: assert property (
    mem_wr_valid && !cur_cfg_ff.host && busy |-> mem_wr.desc)
    else $error("monolithic packet wrote a buffer");
  pop_ptr_a: assert property (
    pop_taken |=> state_ff == st_data && desc_ptr_ff == $past(qm_pop_data) ##0 !qm_pop_req)
    else $error("popped pointer not taken");
  w0_fields_a: assert property (
    w0_issue |=> mem_wr.data[`PDH_W0_LEN_MSB:0] == len_ff &&
      mem_wr.data[`PDH_W0_TYPE_MSB:`PDH_W0_TYPE_LSB] ==
      (cur_cfg_ff.host ? `PDH_TYPE_HOST : `PDH_TYPE_MONO))
    else $error("word 0 fields disturbed");
endmodule
`default_nettype wire

// file: tb/pdh_far_model.sv
`default_nettype none
module pdh_far_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic stall,
  input wire logic qm_pop_req,
  output logic qm_pop_ack,
  output logic [31:0] qm_pop_data,
  input wire logic qm_push_valid,
  output logic qm_push_ready,
  input wire logic mem_wr_valid,
  output logic mem_wr_ready,
  input wire pdh_pkg::pdh_mem_wr_t mem_wr
);
  timeunit 1ns;
  timeprecision 100ps;
  import pdh_pkg::*;
  logic [31:0] ptr_ff;
  logic [2:0] wait_ff;
  logic [31:0] mem [logic [31:0]];
  // free queue hands out pointers 0x100 apart; slow mode answers late
  // pop returns pointer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      qm_pop_ack <= 1'b0;
      qm_pop_data <= 32'h0;
      ptr_ff <= 32'h0001_0000;
      wait_ff <= 3'h0;
    end else if (qm_pop_req && !qm_pop_ack && wait_ff >= (slow ? 3'h5 : 3'h0)) begin
      qm_pop_ack <= 1'b1;
      qm_pop_data <= ptr_ff;
      ptr_ff <= ptr_ff + 32'h100;
      wait_ff <= 3'h0;
    end else begin
      qm_pop_ack <= 1'b0;
      qm_pop_data <= ~qm_pop_data; // stale pointer shows only on every other cycle between answers
      wait_ff <= qm_pop_req ? wait_ff + 3'h1 : 3'h0;
    end
  end
  // memory merges byte lanes, so partial descriptor writes are safe here
  // partial writes accepted
  always_ff @(posedge core_clk) begin
    if (rst_b && mem_wr_valid && mem_wr_ready) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_wr.be[b]) mem[mem_wr.addr][8*b +: 8] <= mem_wr.data[8*b +: 8];
      end
    end
  end
  // slow mode stalls memory and push at random
  // push is one beat, so no split register group
  assign mem_wr_ready = !(slow && stall);
  assign qm_push_ready = !(slow && stall);
endmodule
`default_nettype wire

// file: tb/pdh_rx_dma_tb.sv
`default_nettype none
`include "pdh_regs.svh"
module pdh_rx_dma_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pdh_pkg::*;
  logic core_clk, rst_b, chan_en, flow_cfg_we, fwd_en, s_valid, s_ready, slow, stall;
  logic qm_pop_req, qm_pop_ack, qm_push_valid, qm_push_ready, mem_wr_valid, mem_wr_ready, busy;
  logic [2:0] flow_cfg_idx;
  logic [31:0] fwd_word0, qm_pop_data, qm_push_ptr;
  pdh_flow_cfg_t flow_cfg;
  pdh_beat_t s_beat;
  pdh_mem_wr_t mem_wr;
  pdh_mem_wr_t eq[$];
  logic [31:0] em[$];
  logic [15:0] lf, st;
  int miscompares, checks, pushes;
  // columns: flow, ps_in_buf, host, tag_pass, ps words, data words, fwd, fwd bit
  int tab [6][8] = '{'{0, 1, 1, 1, 2, 3, 0, 0}, '{1, 0, 1, 0, 2, 2, 0, 0},
    '{2, 1, 0, 1, 1, 2, 0, 0}, '{3, 0, 1, 0, 0, 1, 1, 1}, '{4, 1, 1, 1, 0, 2, 1, 0},
    '{0, 0, 1, 0, 1, 19, 0, 0}};
  pdh_rx_dma DUT (.core_clk(core_clk), .rst_b(rst_b), .chan_en(chan_en),
    .flow_cfg_we(flow_cfg_we), .flow_cfg_idx(flow_cfg_idx), .flow_cfg(flow_cfg),
    .fwd_en(fwd_en), .fwd_word0(fwd_word0), .s_valid(s_valid), .s_ready(s_ready),
    .s_beat(s_beat), .qm_pop_req(qm_pop_req), .qm_pop_ack(qm_pop_ack),
    .qm_pop_data(qm_pop_data), .qm_push_valid(qm_push_valid),
    .qm_push_ready(qm_push_ready), .qm_push_ptr(qm_push_ptr), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr), .busy(busy));
  pdh_far_model far (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .stall(stall),
    .qm_pop_req(qm_pop_req), .qm_pop_ack(qm_pop_ack), .qm_pop_data(qm_pop_data),
    .qm_push_valid(qm_push_valid), .qm_push_ready(qm_push_ready),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a zero byte-enable entry means the byte enables are not checked
  task automatic exp_wr(input logic [31:0] a, d, m, input logic [3:0] be, input logic dsc);
    eq.push_back('{addr: a, data: d, be: be, desc: dsc});
    em.push_back(m);
  endtask
  task automatic run_pkt(input int r);
    int nps, nd, k;
    logic host, loc, inb;
    logic [31:0] ptr, tag, base;
    logic [21:0] len;
    logic [31:0] wq[$];
    nps = tab[r][4];
    nd = tab[r][5];
    host = tab[r][2] != 0;
    loc = host && (tab[r][6] != 0 ? tab[r][7] != 0 : tab[r][1] != 0);
    ptr = 32'h0001_0000 + 32'(r) * 32'h100;
    len = 22'(4 * nd);
    tag = {lf, ~lf};
    // program this flow, then scramble a neighbour so a wrong index shows
    flow_cfg_we = 1'b1;
    flow_cfg_idx = 3'(tab[r][0]);
    flow_cfg = '{ps_in_buf: tab[r][1] != 0, host: host, tag_pass: tab[r][3] != 0};
    @(posedge core_clk);
    #1;
    flow_cfg_idx = 3'(tab[r][0]) ^ 3'h1;
    flow_cfg = ~flow_cfg;
    @(posedge core_clk);
    #1;
    flow_cfg_we = 1'b0;
    fwd_en = tab[r][6] != 0;
    fwd_word0 = {lf, ~lf};
    fwd_word0[22] = tab[r][7] != 0;
    slow = r[0];
    chan_en = r != 5;
    // stream words land in order: buffer words whole, the rest in the descriptor
    for (k = 0; k < nps + nd; k++) begin
      wq.push_back({lf, lf ^ 16'h5a5a});
      lf = nx(lf);
      inb = host && (k >= nps || loc);
      if (!inb) base = 32'h10 + 32'(4 * k);
      else base = `PDH_OFS_BUF + 32'(4 * ((loc || k < nps) ? k : k - nps));
      exp_wr(ptr + base, wq[k], 32'hffff_ffff, inb ? `PDH_BE_FULL : 4'h0, !inb);
    end
    exp_wr(ptr, {host ? `PDH_TYPE_HOST : `PDH_TYPE_MONO, 7'h00, loc, len}, '1, 4'h0, 1'b1);
    exp_wr(ptr + 32'h4, 32'(len), 32'h00ff_ffff, `PDH_BE_LEN, 1'b1);
    if (tab[r][3] != 0) exp_wr(ptr + 32'h8, tag, '1, 4'h0, 1'b1);
    if (host) exp_wr(ptr + 32'hc, ptr + `PDH_OFS_BUF, '1, 4'h0, 1'b1);
    if (r == 5) begin
      fork
        begin
          repeat (40) @(posedge core_clk);
          #1;
          chk("fifo full ready", 32'(s_ready), 32'h0);
          chan_en = 1'b1;
        end
      join_none
    end
    for (k = 0; k < nps + nd; k++) begin
      s_valid = 1'b1;
      s_beat = '{tag: tag, flow: 3'(tab[r][0]), sop: k == 0, eop: k == nps + nd - 1,
        ps: k < nps, data: wq[k]};
      do @(posedge core_clk); while (s_ready !== 1'b1);
      #1;
    end
    s_valid = 1'b0;
    s_beat = ~s_beat;
    k = 0;
    while (pushes < r + 1 && k < 400) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    @(posedge core_clk);
    #1;
    chk("busy after push", 32'(busy), 32'h0);
    fwd_en = 1'b0;
  endtask
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  // stall pattern for the slow far side
  always @(posedge core_clk) begin
    #1;
    st = nx(st);
    stall = st[0];
  end
  // every accepted write and push is compared against the bench model
  always @(posedge core_clk) begin
    if (rst_b && mem_wr_valid && mem_wr_ready) begin
      if (eq.size() == 0) chk("extra write", 32'h1, 32'h0);
      else begin
        chk("addr", mem_wr.addr, eq[0].addr);
        chk("data", mem_wr.data & em[0], eq[0].data & em[0]);
        if (eq[0].be != 4'h0) chk("be", 32'(mem_wr.be), 32'(eq[0].be));
        chk("desc", 32'(mem_wr.desc), 32'(eq[0].desc));
        void'(eq.pop_front());
        void'(em.pop_front());
      end
    end
    if (rst_b && qm_push_valid && qm_push_ready) begin
      chk("push ptr", qm_push_ptr, 32'h0001_0000 + 32'(pushes) * 32'h100);
      pushes++;
    end
  end
  initial begin
    {rst_b, chan_en, flow_cfg_we, fwd_en, s_valid, slow, stall} = '0;
    flow_cfg_idx = 3'h0;
    flow_cfg = '0;
    fwd_word0 = 32'h0;
    s_beat = '0;
    lf = 16'h4;
    st = 16'h4;
    repeat (12) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("ready after reset", 32'(s_ready), 32'h1);
    for (int r = 0; r < 6; r++) run_pkt(r);
    chk("writes left", 32'(eq.size()), 32'h0);
    give_verdict();
  end
  // watchdog sized well past the six packets
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
